// ---- twowire_cfg.svh ----
`ifndef TWOWIRE_CFG_SVH
`define TWOWIRE_CFG_SVH

// device type codes in the upper nibble of the address byte
`define SENSOR_TYPE_CODE 4'h3
`define EEPROM_TYPE_CODE 4'ha

// half-select and half-query control bytes
`define HALF_SEL_LOWER 8'h6c
`define HALF_SEL_UPPER 8'h6e
`define HALF_QUERY 8'h6d
`define HALF_SEL_BIT 1

// array layout
`define PAGE_OFFSET_BITS 4
`define QUADRANT_BIT 7
`define DONT_CARE_BYTE 8'hff
`define BITS_PER_BYTE 4'h8

// reset values
`define HALF_RESET 1'b0
`define QUAD_WP_RESET 4'h0
`define POINTER_RESET 8'h00

`endif

// ---- twowire_pkg.sv ----
package twowire_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_RX   = 7'b0000100,
    ST_ACK  = 7'b0001000,
    ST_TX   = 7'b0010000,
    ST_MACK = 7'b0100000,
    ST_WAIT = 7'b1000000
  } bus_state_t;

  typedef enum logic [3:0] {
    K_SENSOR = 4'b0001,
    K_EEPROM = 4'b0010,
    K_HSEL   = 4'b0100,
    K_HQUERY = 4'b1000
  } xfer_kind_t;

endpackage

// ---- line_evt_if.sv ----
`timescale 1ns/100ps
interface line_evt_if;
  logic sclRise;
  logic sclFall;
  logic sdaBit;
  logic startDet;
  logic stopDet;
  modport src (output sclRise, output sclFall, output sdaBit, output startDet, output stopDet);
  modport dst (input sclRise, input sclFall, input sdaBit, input startDet, input stopDet);
endinterface

// ---- twowire_line_sync.sv ----
`timescale 1ns/100ps
module twowire_line_sync #(
  parameter int syncStages = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  // line events
  line_evt_if.src lv
);

  if (syncStages < 2) begin : gen_check
    $error("twowire_line_sync needs at least two synchroniser stages");
  end

  logic [syncStages-1:0] sclSync_reg;
  logic [syncStages-1:0] sdaSync_reg;
  logic sclLast_reg;
  logic sdaLast_reg;
  logic sclNow;
  logic sdaNow;

  assign sclNow = sclSync_reg[syncStages-1];
  assign sdaNow = sdaSync_reg[syncStages-1];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclSync_reg <= '1;
      sdaSync_reg <= '1;
    end else begin
      sclSync_reg <= {sclSync_reg[syncStages-2:0], sclIn};
      sdaSync_reg <= {sdaSync_reg[syncStages-2:0], sdaIn};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclLast_reg <= 1'b1;
      sdaLast_reg <= 1'b1;
    end else begin
      sclLast_reg <= sclNow;
      sdaLast_reg <= sdaNow;
    end
  end

  assign lv.sclRise = sclNow & ~sclLast_reg;
  assign lv.sclFall = ~sclNow & sclLast_reg;
  assign lv.sdaBit = sdaNow;
  // data moving while the clock stays high frames a transfer
  assign lv.startDet = sclNow & sclLast_reg & sdaLast_reg & ~sdaNow;
  assign lv.stopDet = sclNow & sclLast_reg & ~sdaLast_reg & sdaNow;

endmodule

// ---- sensor_eeprom_twowire_front_end.sv ----
`timescale 1ns/100ps
`include "twowire_cfg.svh"
module sensor_eeprom_twowire_front_end
  import twowire_pkg::*;
#(
  parameter logic [2:0] devSelect = 3'h0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // control inputs
  input wire logic hvDetect,
  input wire logic softReset,
  input wire logic [3:0] wpSet,
  input wire logic [3:0] wpClr,
  // status
  output logic halfSelect,
  output logic [3:0] quadWriteProtect,
  // thermal_sensor register port
  output logic [7:0] regPointer,
  output logic [15:0] regWrData,
  output logic regWrStrobe,
  input wire logic [15:0] regRdData,
  // eeprom array port
  output logic [8:0] eeAddr,
  output logic [7:0] eeWrData,
  output logic eeWrStrobe,
  output logic eeRdStrobe,
  input wire logic [7:0] eeRdData
);

  line_evt_if lv();

  twowire_line_sync #(.syncStages(2)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .lv(lv.src)
  );

  bus_state_t state_reg;
  xfer_kind_t kind_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] txShift_reg;
  logic [1:0] byteIdx_reg;
  logic rw_reg;
  logic masterAck_reg;
  logic sdaOe_reg;
  logic sdaOut_reg;
  logic half_reg;
  logic [3:0] wp_reg;
  logic [7:0] pointer_reg;
  logic [7:0] wrHi_reg;
  logic [15:0] regWrData_reg;
  logic regWrStrobe_reg;
  logic [15:0] word_reg;
  logic [7:0] addrCnt_reg;
  logic [8:0] eeAddr_reg;
  logic [7:0] eeWrData_reg;
  logic eeWrStrobe_reg;
  logic eeRdStrobe_reg;
  logic [1:0] hvSync_reg;

  logic addrDone;
  logic rxDone;
  logic ackEnd;
  logic halfCmd;
  logic halfSetReq;
  logic wpHit;
  logic [1:0] idxNext;
  logic [7:0] txByte;

  assign addrDone = (state_reg == ST_ADDR) && lv.sclFall && (bitCnt_reg == `BITS_PER_BYTE);
  assign rxDone = (state_reg == ST_RX) && lv.sclFall && (bitCnt_reg == `BITS_PER_BYTE);
  assign ackEnd = (state_reg == ST_ACK) && lv.sclFall;
  assign halfCmd = (shift_reg == `HALF_SEL_LOWER) || (shift_reg == `HALF_SEL_UPPER);
  assign halfSetReq = addrDone && hvSync_reg[1] && halfCmd;
  assign wpHit = wp_reg[{half_reg, addrCnt_reg[`QUADRANT_BIT]}];
  assign idxNext = (byteIdx_reg == 2'h3) ? byteIdx_reg : byteIdx_reg + 2'h1;

  // next byte to send, chosen by the index it will carry
  always_comb begin
    txByte = `DONT_CARE_BYTE;
    if (kind_reg == K_SENSOR) begin
      if (state_reg == ST_ACK) begin
        txByte = regRdData[15:8];
      end else begin
        txByte = idxNext[0] ? word_reg[7:0] : word_reg[15:8];
      end
    end else if (kind_reg == K_EEPROM) begin
      txByte = eeRdData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hvSync_reg <= 2'h0;
    end else begin
      hvSync_reg <= {hvSync_reg[0], hvDetect};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      half_reg <= `HALF_RESET;
    end else if (softReset) begin
      half_reg <= `HALF_RESET;
    end else if (halfSetReq) begin
      half_reg <= shift_reg[`HALF_SEL_BIT];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wp_reg <= `QUAD_WP_RESET;
    end else begin
      wp_reg <= (wp_reg & ~wpClr) | wpSet;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      eeAddr_reg <= 9'h000;
      sdaOut_reg <= 1'b0;
    end else begin
      eeAddr_reg <= {half_reg, addrCnt_reg};
      sdaOut_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      kind_reg <= K_SENSOR;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      txShift_reg <= 8'h00;
      byteIdx_reg <= 2'h0;
      rw_reg <= 1'b0;
      masterAck_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
      pointer_reg <= `POINTER_RESET;
      wrHi_reg <= 8'h00;
      regWrData_reg <= 16'h0000;
      regWrStrobe_reg <= 1'b0;
      word_reg <= 16'h0000;
      addrCnt_reg <= 8'h00;
      eeWrData_reg <= 8'h00;
      eeWrStrobe_reg <= 1'b0;
      eeRdStrobe_reg <= 1'b0;
    end else begin
      regWrStrobe_reg <= 1'b0;
      eeWrStrobe_reg <= 1'b0;
      eeRdStrobe_reg <= 1'b0;
      if (lv.stopDet) begin
        state_reg <= ST_IDLE;
        sdaOe_reg <= 1'b0;
      end else if (lv.startDet) begin
        state_reg <= ST_ADDR;
        bitCnt_reg <= 4'h0;
        sdaOe_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_RX: begin
            if (lv.sclRise && bitCnt_reg != `BITS_PER_BYTE) begin
              shift_reg <= {shift_reg[6:0], lv.sdaBit};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (addrDone) begin
              bitCnt_reg <= 4'h0;
              byteIdx_reg <= 2'h0;
              rw_reg <= shift_reg[0];
              state_reg <= ST_ACK;
              sdaOe_reg <= 1'b1;
              if (shift_reg[7:1] == {`SENSOR_TYPE_CODE, devSelect}) begin
                kind_reg <= K_SENSOR;
              end else if (shift_reg[7:1] == {`EEPROM_TYPE_CODE, devSelect}) begin
                kind_reg <= K_EEPROM;
              end else if (halfSetReq) begin
                kind_reg <= K_HSEL;
              end else if (hvSync_reg[1] && shift_reg == `HALF_QUERY) begin
                kind_reg <= K_HQUERY;
                sdaOe_reg <= ~half_reg;
              end else begin
                state_reg <= ST_WAIT;
                sdaOe_reg <= 1'b0;
              end
            end else if (rxDone) begin
              bitCnt_reg <= 4'h0;
              byteIdx_reg <= idxNext;
              state_reg <= ST_ACK;
              sdaOe_reg <= 1'b1;
              if (kind_reg == K_SENSOR) begin
                if (byteIdx_reg == 2'h0) begin
                  pointer_reg <= shift_reg;
                end else if (byteIdx_reg == 2'h1) begin
                  wrHi_reg <= shift_reg;
                end else if (byteIdx_reg == 2'h2) begin
                  regWrData_reg <= {wrHi_reg, shift_reg};
                  regWrStrobe_reg <= 1'b1;
                end
              end else if (kind_reg == K_EEPROM) begin
                if (byteIdx_reg == 2'h0) begin
                  addrCnt_reg <= shift_reg;
                end else if (wpHit) begin
                  sdaOe_reg <= 1'b0;
                end else begin
                  eeWrData_reg <= shift_reg;
                  eeWrStrobe_reg <= 1'b1;
                  addrCnt_reg[`PAGE_OFFSET_BITS-1:0] <= addrCnt_reg[`PAGE_OFFSET_BITS-1:0] + 4'h1;
                end
              end
            end
          end
          ST_ACK: begin
            if (lv.sclFall) begin
              bitCnt_reg <= 4'h0;
              if (rw_reg || kind_reg == K_HQUERY) begin
                state_reg <= ST_TX;
                txShift_reg <= txByte;
                sdaOe_reg <= ~txByte[7];
                if (kind_reg == K_SENSOR) begin
                  word_reg <= regRdData;
                end else if (kind_reg == K_EEPROM) begin
                  addrCnt_reg <= addrCnt_reg + 8'h01;
                  eeRdStrobe_reg <= 1'b1;
                end
              end else begin
                state_reg <= ST_RX;
                sdaOe_reg <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (lv.sclRise) begin
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (lv.sclFall) begin
              if (bitCnt_reg == `BITS_PER_BYTE) begin
                state_reg <= ST_MACK;
                sdaOe_reg <= 1'b0;
              end else begin
                txShift_reg <= {txShift_reg[6:0], 1'b0};
                sdaOe_reg <= ~txShift_reg[6];
              end
            end
          end
          ST_MACK: begin
            if (lv.sclRise) begin
              masterAck_reg <= ~lv.sdaBit;
            end else if (lv.sclFall) begin
              bitCnt_reg <= 4'h0;
              byteIdx_reg <= idxNext;
              // query keeps sending its second byte even after a nack
              if (masterAck_reg || (kind_reg == K_HQUERY && byteIdx_reg == 2'h0)) begin
                state_reg <= ST_TX;
                txShift_reg <= txByte;
                sdaOe_reg <= ~txByte[7];
                if (kind_reg == K_EEPROM) begin
                  addrCnt_reg <= addrCnt_reg + 8'h01;
                  eeRdStrobe_reg <= 1'b1;
                end
              end else begin
                state_reg <= ST_WAIT;
              end
            end
          end
          ST_WAIT, ST_IDLE: begin
            sdaOe_reg <= 1'b0;
          end
          default: begin
            state_reg <= ST_IDLE;
            sdaOe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sdaOut = sdaOut_reg;
  assign sdaOe = sdaOe_reg;
  assign halfSelect = half_reg;
  assign quadWriteProtect = wp_reg;
  assign regPointer = pointer_reg;
  assign regWrData = regWrData_reg;
  assign regWrStrobe = regWrStrobe_reg;
  assign eeAddr = eeAddr_reg;
  assign eeWrData = eeWrData_reg;
  assign eeWrStrobe = eeWrStrobe_reg;
  assign eeRdStrobe = eeRdStrobe_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_HALF_CLEAR: assert property (softReset |=> !half_reg)
    else $error("half select not cleared by software reset");
  AST_HALF_SET: assert property (halfSetReq && !softReset |=> half_reg == $past(shift_reg[1]) && sdaOe_reg)
    else $error("half select command not applied or not acked");
  AST_HV_GATE: assert property (addrDone && !hvSync_reg[1] && (halfCmd || shift_reg == `HALF_QUERY)
    |=> state_reg == ST_WAIT && !sdaOe_reg)
    else $error("half command answered without high voltage");
  AST_QUERY_ANSWER: assert property (addrDone && hvSync_reg[1] && shift_reg == `HALF_QUERY && !softReset
    |=> sdaOe_reg == !half_reg)
    else $error("half query answer wrong");
  AST_SEL_DATA_ACK: assert property (rxDone && kind_reg == K_HSEL |=> state_reg == ST_ACK && sdaOe_reg)
    else $error("half select data byte not acked");
  AST_WP_BLOCK: assert property (rxDone && kind_reg == K_EEPROM && byteIdx_reg != 2'h0 && wpHit
    |=> !eeWrStrobe_reg && !sdaOe_reg)
    else $error("write reached a protected quadrant");
  AST_ARRAY_ADDR: assert property (eeWrStrobe_reg |-> eeAddr_reg == {$past(half_reg), $past(addrCnt_reg)})
    else $error("array address not half over word address");
  AST_PAGE_ROLL: assert property (eeWrStrobe_reg |-> addrCnt_reg[7:4] == $past(addrCnt_reg[7:4])
    && addrCnt_reg[3:0] == $past(addrCnt_reg[3:0]) + 4'h1)
    else $error("page address did not wrap within page");
  AST_POINTER_KEEP: assert property ($changed(pointer_reg)
    |-> $past(rxDone && kind_reg == K_SENSOR && byteIdx_reg == 2'h0))
    else $error("pointer changed outside pointer byte");
  AST_SENSOR_WRITE: assert property (regWrStrobe_reg |-> $past(kind_reg == K_SENSOR && byteIdx_reg == 2'h2)
    && regWrData_reg[7:0] == $past(shift_reg))
    else $error("sensor write not after two data bytes");
  AST_READ_HIGH: assert property (ackEnd && rw_reg && kind_reg == K_SENSOR && !lv.stopDet && !lv.startDet
    |=> state_reg == ST_TX && txShift_reg == $past(regRdData[15:8]))
    else $error("sensor read did not start with high byte");

  COV_SENSOR_WRITE: cover property (regWrStrobe_reg);
  COV_EEPROM_WRITE: cover property (eeWrStrobe_reg);
  COV_HALF_SET: cover property (halfSetReq ##1 half_reg);
  COV_QUERY_NACK: cover property (addrDone && shift_reg == `HALF_QUERY && half_reg && hvSync_reg[1]);

endmodule

// ---- twowire_master_model.sv ----
`timescale 1ns/100ps
module twowire_master_model (
  // clock
  input wire logic ref_clk,
  // bus lines
  input wire logic sdaLine,
  output logic sclOut,
  output logic sdaPull
);
  // clock idles high, data released to the pull-up
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end

  // quarter of the 80 ns bus period
  task automatic qtr();
    repeat (2) @(negedge ref_clk);
  endtask

  // data moves only while the clock is low
  task automatic bitC(input logic drv, output logic smp);
    sclOut = 1'b0;
    qtr();
    sdaPull = ~drv;
    qtr();
    sclOut = 1'b1;
    qtr();
    smp = sdaLine;
    qtr();
  endtask

  task automatic startC();
    sclOut = 1'b0;
    qtr();
    sdaPull = 1'b0;
    qtr();
    sclOut = 1'b1;
    qtr();
    sdaPull = 1'b1;
    qtr();
  endtask

  task automatic stopC();
    sclOut = 1'b0;
    qtr();
    sdaPull = 1'b1;
    qtr();
    sclOut = 1'b1;
    qtr();
    sdaPull = 1'b0;
    qtr();
  endtask

  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      bitC(b[i], d);
    end
    bitC(1'b1, d);
    ack = ~d;
  endtask

  task automatic rdByte(input logic ackIt, output logic [7:0] b);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      bitC(1'b1, d);
      b[i] = d;
    end
    bitC(~ackIt, d);
  endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic ref_clk;
  logic rst;
  logic sclLine;
  logic mPull;
  wire sdaLine;
  logic sdaOut, sdaOe, hvDetect, softReset, halfSelect, regWrStrobe, eeWrStrobe, eeRdStrobe;
  logic [3:0] wpSet, wpClr, quadWriteProtect;
  logic [7:0] regPointer, eeWrData;
  logic [15:0] regWrData;
  logic [15:0] wrSeen = 16'h0;
  logic [8:0] eeAddr;
  logic [8:0] eeSeen = 9'h0;
  int nErrors = 0;
  int testsRun = 0;
  int nWr = 0;
  int nEe = 0;
  int nRd = 0;
  int cyc = 0;

  // open drain with pull-up
  assign sdaLine = (mPull | sdaOe) ? 1'b0 : 1'b1;
  wire [15:0] regRdData = {regPointer, ~regPointer};
  wire [7:0] eeRdData = eeAddr[7:0] ^ 8'h3c;

  twowire_master_model twowire_master_model_i (.ref_clk(ref_clk), .sdaLine(sdaLine), .sclOut(sclLine),
    .sdaPull(mPull));

  sensor_eeprom_twowire_front_end sensor_eeprom_twowire_front_end_i (.ref_clk(ref_clk), .rst(rst),
    .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .hvDetect(hvDetect),
    .softReset(softReset), .wpSet(wpSet), .wpClr(wpClr), .halfSelect(halfSelect),
    .quadWriteProtect(quadWriteProtect), .regPointer(regPointer), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdData(regRdData), .eeAddr(eeAddr), .eeWrData(eeWrData),
    .eeWrStrobe(eeWrStrobe), .eeRdStrobe(eeRdStrobe), .eeRdData(eeRdData));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic testDone();
    if (nErrors == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // strobe capture and hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (regWrStrobe === 1'b1) begin
      wrSeen <= regWrData;
      nWr <= nWr + 1;
    end
    if (eeWrStrobe === 1'b1) begin
      eeSeen <= eeAddr;
      nEe <= nEe + 1;
    end
    if (eeRdStrobe === 1'b1) begin
      nRd <= nRd + 1;
    end
    if (cyc == 20000) begin
      nErrors++;
      testDone();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] b, input logic expAck);
    logic ack;
    twowire_master_model_i.wrByte(b, ack);
    chk($sformatf("ack after %h", b), {15'h0, expAck}, {15'h0, ack});
  endtask

  task automatic rd(input logic ackIt, input logic [7:0] exp);
    logic [7:0] b;
    twowire_master_model_i.rdByte(ackIt, b);
    chk("read byte", {8'h0, exp}, {8'h0, b});
  endtask

  task automatic sel(input logic [7:0] ctl, input logic expAck);
    twowire_master_model_i.startC();
    wr(ctl, expAck);
    if (ctl == 8'h6d) begin
      rd(1'b0, 8'hff);
      rd(1'b0, 8'hff);
    end else if (expAck) begin
      wr(8'h00, 1'b1);
      wr(8'hff, 1'b1);
    end
    twowire_master_model_i.stopC();
  endtask

  task automatic eeWr(input logic [7:0] word, input logic [7:0] data, input logic expAck);
    twowire_master_model_i.startC();
    wr(8'ha0, 1'b1);
    wr(word, 1'b1);
    wr(data, expAck);
    twowire_master_model_i.stopC();
  endtask

  // control pins change at the falling edge; strobes last one cycle
  task automatic pins(input logic hv, input logic sr, input logic [3:0] s, input logic [3:0] c);
    @(negedge ref_clk);
    hvDetect = hv;
    softReset = sr;
    wpSet = s;
    wpClr = c;
    @(negedge ref_clk);
    softReset = 1'b0;
    wpSet = 4'h0;
    wpClr = 4'h0;
    repeat (3) @(negedge ref_clk);
  endtask

  initial begin
    rst = 1'b1;
    hvDetect = 1'b0;
    softReset = 1'b0;
    wpSet = 4'h0;
    wpClr = 4'h0;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("halfSelect", 16'h0, {15'h0, halfSelect});
    chk("regPointer", 16'h0, {8'h0, regPointer});
    chk("quadWriteProtect", 16'h0, {12'h0, quadWriteProtect});
    twowire_master_model_i.startC();
    wr(8'h30, 1'b1);
    wr(8'h05, 1'b1);
    wr(8'ha5, 1'b1);
    wr(8'h3c, 1'b1);
    twowire_master_model_i.stopC();
    chk("regPointer", 16'h05, {8'h0, regPointer});
    chk("regWrData", 16'ha53c, wrSeen);
    chk("write count", 16'h1, 16'(nWr));
    // two reads with no pointer byte hit the same register
    for (int k = 0; k < 2; k++) begin
      twowire_master_model_i.startC();
      wr(8'h31, 1'b1);
      rd(1'b1, 8'h05);
      rd(1'b0, 8'hfa);
      twowire_master_model_i.stopC();
    end
    twowire_master_model_i.startC();
    wr(8'h30, 1'b1);
    wr(8'h07, 1'b1);
    twowire_master_model_i.startC();
    wr(8'h31, 1'b1);
    rd(1'b1, 8'h07);
    rd(1'b0, 8'hf8);
    twowire_master_model_i.stopC();
    sel(8'h6e, 1'b0);
    chk("halfSelect", 16'h0, {15'h0, halfSelect});
    pins(1'b1, 1'b0, 4'h0, 4'h0);
    sel(8'h6e, 1'b1);
    chk("halfSelect", 16'h1, {15'h0, halfSelect});
    sel(8'h6d, 1'b0);
    pins(1'b1, 1'b1, 4'h0, 4'h0);
    chk("halfSelect", 16'h0, {15'h0, halfSelect});
    sel(8'h6d, 1'b1);
    sel(8'h6e, 1'b1);
    pins(1'b1, 1'b0, 4'h8, 4'h0);
    chk("quadWriteProtect", 16'h8, {12'h0, quadWriteProtect});
    eeWr(8'h85, 8'h5a, 1'b0);
    chk("array writes", 16'h0, 16'(nEe));
    eeWr(8'h05, 8'h5a, 1'b1);
    chk("eeAddr", 16'h105, {7'h0, eeSeen});
    sel(8'h6c, 1'b1);
    eeWr(8'h85, 8'h5a, 1'b1);
    chk("eeAddr", 16'h085, {7'h0, eeSeen});
    pins(1'b1, 1'b0, 4'h0, 4'h8);
    chk("quadWriteProtect", 16'h0, {12'h0, quadWriteProtect});
    sel(8'h6e, 1'b1);
    // page of 16 wraps from its last byte to its first
    twowire_master_model_i.startC();
    wr(8'ha0, 1'b1);
    wr(8'h8f, 1'b1);
    wr(8'h11, 1'b1);
    wr(8'h22, 1'b1);
    twowire_master_model_i.stopC();
    chk("eeAddr", 16'h180, {7'h0, eeSeen});
    chk("array writes", 16'h4, 16'(nEe));
    chk("eeWrData", 16'h22, {8'h0, eeWrData});
    // array read in the upper half, counter steps per byte
    twowire_master_model_i.startC();
    wr(8'ha0, 1'b1);
    wr(8'h10, 1'b1);
    twowire_master_model_i.startC();
    wr(8'ha1, 1'b1);
    rd(1'b1, 8'h2c);
    rd(1'b0, 8'h2d);
    twowire_master_model_i.stopC();
    chk("array reads", 16'h2, 16'(nRd));
    chk("eeAddr", 16'h112, {7'h0, eeAddr});
    chk("sdaOut", 16'h0, {15'h0, sdaOut});
    testDone();
  end
endmodule
